// ### verilog/dmpc_pkg.sv
// Constants and types for the device mode protection control block
package dmpc_pkg;

    // ************************************************************
    // Lifecycle modes and their stored configuration codes
    // ************************************************************
    typedef enum logic [1:0] {MODE_VIRGIN, MODE_INIT, MODE_PROTECTED, MODE_TAMPERED} dmpc_mode_e;

    localparam logic [7:0] CFG_VIRGIN    = 8'h5a;
    localparam logic [7:0] CFG_INIT      = 8'h3c;
    localparam logic [7:0] CFG_PROTECTED = 8'ha5;
    localparam logic [7:0] CFG_TAMPERED  = 8'hc3;

    // ************************************************************
    // Monitor commands
    // ************************************************************
    localparam logic [7:0] CMD_STATUS      = 8'h01;
    localparam logic [7:0] CMD_PROGRAM     = 8'h02;
    localparam logic [7:0] CMD_READ        = 8'h03;
    localparam logic [7:0] CMD_PROTECT     = 8'h04;
    localparam logic [7:0] CMD_RETURN_INIT = 8'h05;
    localparam logic [7:0] CMD_LEAVE_VIRGIN = 8'h06;
    localparam logic [7:0] CMD_BREAK       = 8'h10;
    localparam logic [7:0] CMD_RESUME      = 8'h11;
    localparam logic [7:0] CMD_STEP        = 8'h12;
    localparam logic [7:0] CMD_DBG_LAST    = 8'h17;

    // ************************************************************
    // Code memory layout
    // ************************************************************
    localparam int         BLOCK_BYTES    = 64;
    localparam logic [6:0] BLOCK_LAST     = 7'h3f;
    localparam logic [6:0] READ_END       = 7'h41;
    localparam logic [7:0] CFG_BLOCK      = 8'hff;
    localparam logic [9:0] CFG_BLOCK_ADDR = 10'h0ff;
    localparam logic [15:0] CFG_ADDR      = 16'h3fc0;
    localparam logic [15:0] WARM_BOOT_VEC = 16'h0100;

    // ************************************************************
    // Status byte fields and timing
    // ************************************************************
    localparam int ST_REJECT = 7;
    localparam int ST_HALT   = 6;
    localparam int ST_BUSY   = 5;
    localparam int CLK_MHZ      = 10;
    localparam int LINK_IDLE_US = 100;
    localparam int LINK_IDLE_CYC = LINK_IDLE_US * CLK_MHZ;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [2:0] {MEM_READ, MEM_WRITE, MEM_ERASE, MEM_CFG_RD, MEM_CFG_WR} dmpc_mop_e;

    typedef struct packed {
        dmpc_mop_e   op;
        logic [15:0] addr;
        logic [7:0]  data;
    } dmpc_mreq_s;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] operand;
    } dmpc_dbg_s;

endpackage : dmpc_pkg

// ### verilog/dmpc_core.sv
// Lifecycle mode control with cold boot hand-off and monitor port gating
`timescale 1ns/10ps
// Overview of operation
// - Four lifecycle modes govern port and memory access
// - Mode bytes in memory; only monitor commands change
// - Factory devices leave in development mode
// - Development mode allows full monitor and programming
// - Break command halts application until resume, protect command, wake-up or reset
// - Protected mode blocks memory access and debug
// - Return command erases memory then resumes development
// - Tampered during return; stays tampered on failure
// - Repeated return from tampered retries erase sequence
// - Virgin mode left once, never re-entered
// - Cold boot after every reset and wake-up
// - Boot decodes mode, applies flags, jumps warm vector
// - Boot leaves wake and reset source records alone
// - Two-wire link: serial data and serial clock
// - Programming works on 64-byte blocks
// - Forwards 16-bit monitor debug features
// - Protected and tampered honour only status and return commands
// - Development mode turns watchdog overflow into NMI
module dmpc_core
    import dmpc_pkg::*;
#(
    parameter int IDLE_CYC = LINK_IDLE_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Power management
    input  wire logic       wake_pwroff,
    // Monitor link pins
    input  wire logic       monitor_serial_clock,
    input  wire logic       monitor_serial_data_i,
    output logic            monitor_serial_data_o,
    output logic            monitor_serial_data_oe,
    // Code memory port
    output logic            mem_valid,
    output dmpc_mreq_s      mem_req,
    input  wire logic       mem_ack,
    input  wire logic       mem_ok,
    input  wire logic [7:0] mem_rdata,
    // User code write filter
    input  wire logic       cpu_wr_req,
    input  wire logic [15:0] cpu_wr_addr,
    output logic            cpu_wr_grant,
    // CPU control
    output logic            cpu_start,
    output logic [15:0]     cpu_start_vec,
    output logic            cpu_halt,
    output logic            boot_busy,
    // Mode and flags
    output dmpc_mode_e      mode,
    output logic            debug_en,
    output logic            mon_mem_en,
    output logic            wdt_nmi_en,
    output logic            cmd_reject,
    // Debug engine
    output logic            dbg_valid,
    output dmpc_dbg_s       dbg_cmd
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum {S_BOOT, S_BOOT_W, S_RUN, S_CFG, S_CFG_W, S_ERASE, S_ERASE_W} dmpc_st_e;
    typedef enum {L_CMD, L_BLK, L_TURN, L_PROG, L_READ, L_STAT, L_OPND} dmpc_lst_e;

    dmpc_st_e   st_r;
    dmpc_lst_e  lst_r;
    dmpc_mode_e mode_r;
    dmpc_mode_e tgt_r;
    logic       sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic       sdi_s1_r, sdi_s2_r;
    logic       rise, fall;
    logic [2:0] bit_r;
    logic [7:0] rx_r;
    logic       byte_p_r;
    logic [$clog2(IDLE_CYC+1)-1:0] idle_r;
    logic [7:0] cmd_r;
    logic [7:0] blk_r;
    logic [6:0] idx_r;
    logic [7:0] tx_r;
    logic [7:0] rdbuf_r;
    logic [15:0] opnd_r;
    logic       opnd_cnt_r;
    logic       rej_r;
    logic       lnk_go;
    dmpc_mreq_s lnk_req;
    logic       ret_req, prot_req, lock_req;
    logic       go;
    dmpc_mreq_s req_nxt;
    logic       dev, mem_mode, idle;
    logic       cfg_done;

    assign dev      = (mode_r == MODE_INIT) && (st_r == S_RUN);
    assign mem_mode = dev || ((mode_r == MODE_VIRGIN) && (st_r == S_RUN));
    assign idle     = (st_r == S_RUN) && !mem_valid;

    // ************************************************************
    // Link synchronisers and edge detect
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            sdi_s1_r  <= 1'b0;
            sdi_s2_r  <= 1'b0;
        end else begin
            sclk_s1_r <= monitor_serial_clock;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            sdi_s1_r  <= monitor_serial_data_i;
            sdi_s2_r  <= sdi_s1_r;
        end
    end

    assign rise = sclk_s2_r && !sclk_s3_r;
    assign fall = !sclk_s2_r && sclk_s3_r;

    // ************************************************************
    // Bit and byte framing
    // ************************************************************
    // A stalled host loses its partial byte and the rest of the frame; the decoder returns to command
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bit_r    <= 3'h0;
            rx_r     <= 8'h00;
            byte_p_r <= 1'b0;
            idle_r   <= '0;
        end else begin
            byte_p_r <= rise && (bit_r == 3'h7);
            if (rise || fall) begin
                idle_r <= '0;
            end else if (idle_r != IDLE_CYC[$bits(idle_r)-1:0]) begin
                idle_r <= idle_r + 1'b1;
            end
            if (rise) begin
                rx_r  <= {rx_r[6:0], sdi_s2_r};
                bit_r <= bit_r + 3'h1;
            end else if (idle_r == IDLE_CYC[$bits(idle_r)-1:0]) begin
                bit_r <= 3'h0;
            end
        end
    end

    // ************************************************************
    // Monitor command decoder
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lst_r      <= L_CMD;
            cmd_r      <= 8'h00;
            blk_r      <= 8'h00;
            idx_r      <= 7'h00;
            opnd_r     <= 16'h0000;
            opnd_cnt_r <= 1'b0;
            rej_r      <= 1'b0;
            lnk_go     <= 1'b0;
            lnk_req    <= '0;
            ret_req    <= 1'b0;
            prot_req   <= 1'b0;
            lock_req   <= 1'b0;
            dbg_valid  <= 1'b0;
            dbg_cmd    <= '0;
            cmd_reject <= 1'b0;
        end else begin
            lnk_go     <= 1'b0;
            ret_req    <= 1'b0;
            prot_req   <= 1'b0;
            lock_req   <= 1'b0;
            dbg_valid  <= 1'b0;
            cmd_reject <= 1'b0;
            if (idle_r == IDLE_CYC[$bits(idle_r)-1:0]) begin
                lst_r <= L_CMD;
            end else if (byte_p_r) begin
                case (lst_r)
                    L_CMD: begin
                        cmd_r <= rx_r;
                        rej_r <= 1'b0;
                        if (rx_r == CMD_STATUS) begin
                            lst_r <= L_STAT;
                        end else if ((rx_r == CMD_PROGRAM || rx_r == CMD_READ) && mem_mode) begin
                            lst_r <= L_BLK;
                        end else if (rx_r == CMD_PROTECT && dev) begin
                            prot_req <= 1'b1;
                        end else if (rx_r == CMD_RETURN_INIT && idle
                                     && (mode_r == MODE_PROTECTED || mode_r == MODE_TAMPERED)) begin
                            ret_req <= 1'b1;
                        end else if (rx_r == CMD_LEAVE_VIRGIN && idle && mode_r == MODE_VIRGIN) begin
                            lock_req <= 1'b1;
                        end else if (rx_r >= CMD_BREAK && rx_r <= CMD_DBG_LAST && dev) begin
                            lst_r      <= L_OPND;
                            opnd_cnt_r <= 1'b0;
                        end else begin
                            rej_r      <= 1'b1;
                            cmd_reject <= 1'b1;
                        end
                    end
                    L_BLK: begin
                        blk_r <= rx_r;
                        idx_r <= 7'h00;
                        // Config block only moves through mode commands
                        if (rx_r == CFG_BLOCK || !mem_mode) begin
                            lst_r      <= L_CMD;
                            rej_r      <= 1'b1;
                            cmd_reject <= 1'b1;
                        end else if (cmd_r == CMD_PROGRAM) begin
                            lst_r <= L_PROG;
                        end else begin
                            lst_r   <= L_TURN;
                            lnk_go  <= 1'b1;
                            lnk_req <= '{MEM_READ, {2'h0, rx_r, 6'h00}, 8'h00};
                            idx_r   <= 7'h01;
                        end
                    end
                    L_PROG: begin
                        lnk_go  <= 1'b1;
                        lnk_req <= '{MEM_WRITE, {2'h0, blk_r, idx_r[5:0]}, rx_r};
                        idx_r   <= idx_r + 7'h01;
                        if (idx_r == BLOCK_LAST) begin
                            lst_r <= L_CMD;
                        end
                    end
                    L_TURN, L_READ: begin
                        lst_r <= L_READ;
                        if (idx_r == READ_END) begin
                            lst_r <= L_CMD;
                        end else begin
                            idx_r <= idx_r + 7'h01;
                        end
                        if (idx_r <= BLOCK_LAST) begin
                            lnk_go  <= 1'b1;
                            lnk_req <= '{MEM_READ, {2'h0, blk_r, idx_r[5:0]}, 8'h00};
                        end
                    end
                    L_STAT: begin
                        lst_r <= L_CMD;
                    end
                    L_OPND: begin
                        opnd_r     <= {opnd_r[7:0], rx_r};
                        opnd_cnt_r <= 1'b1;
                        if (opnd_cnt_r) begin
                            lst_r     <= L_CMD;
                            dbg_valid <= dev;
                            dbg_cmd   <= '{cmd_r, {opnd_r[7:0], rx_r}};
                        end
                    end
                    default: begin
                        lst_r <= L_CMD;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Response shifter
    // ************************************************************
    // Read data is fetched one byte ahead so the host sees no gap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_r    <= 8'h00;
            rdbuf_r <= 8'h00;
        end else begin
            if (mem_valid && mem_ack && mem_req.op == MEM_READ) begin
                rdbuf_r <= mem_rdata;
            end
            if (byte_p_r && lst_r == L_CMD && rx_r == CMD_STATUS) begin
                tx_r <= {rej_r, cpu_halt, !idle, 3'h0, mode_r};
                tx_r[ST_REJECT] <= rej_r;
                tx_r[ST_HALT]   <= cpu_halt;
                tx_r[ST_BUSY]   <= !idle;
            end else if (byte_p_r && (lst_r == L_TURN || lst_r == L_READ)) begin
                tx_r <= rdbuf_r;
            end else if (fall && bit_r != 3'h0) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            monitor_serial_data_o  <= 1'b0;
            monitor_serial_data_oe <= 1'b0;
        end else begin
            monitor_serial_data_o  <= tx_r[7];
            monitor_serial_data_oe <= (lst_r == L_READ || lst_r == L_STAT);
        end
    end

    // ************************************************************
    // Mode sequencer
    // ************************************************************
    assign cfg_done = mem_valid && mem_ack;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r          <= S_BOOT;
            mode_r        <= MODE_TAMPERED;
            tgt_r         <= MODE_INIT;
            cpu_start     <= 1'b0;
            cpu_start_vec <= 16'h0000;
        end else begin
            cpu_start <= 1'b0;
            if (wake_pwroff) begin
                st_r <= S_BOOT;
            end else begin
                case (st_r)
                    // Wake and reset source records have no path here
                    S_BOOT: begin
                        st_r <= S_BOOT_W;
                    end
                    S_BOOT_W: begin
                        if (cfg_done) begin
                            st_r          <= S_RUN;
                            cpu_start     <= 1'b1;
                            cpu_start_vec <= WARM_BOOT_VEC;
                            case (mem_rdata)
                                CFG_VIRGIN:    mode_r <= MODE_VIRGIN;
                                CFG_INIT:      mode_r <= MODE_INIT;
                                CFG_PROTECTED: mode_r <= MODE_PROTECTED;
                                // Unknown codes fail safe to tampered
                                default:       mode_r <= MODE_TAMPERED;
                            endcase
                        end
                    end
                    S_RUN: begin
                        if (ret_req) begin
                            tgt_r  <= MODE_TAMPERED;
                            mode_r <= MODE_TAMPERED;
                            st_r   <= S_CFG;
                        end else if (prot_req) begin
                            tgt_r <= MODE_PROTECTED;
                            st_r  <= S_CFG;
                        end else if (lock_req) begin
                            tgt_r <= MODE_INIT;
                            st_r  <= S_CFG;
                        end
                    end
                    S_CFG: begin
                        st_r <= S_CFG_W;
                    end
                    S_CFG_W: begin
                        if (cfg_done) begin
                            st_r <= S_RUN;
                            if (!mem_ok) begin
                                st_r <= S_RUN;
                            end else if (tgt_r == MODE_TAMPERED) begin
                                st_r <= S_ERASE;
                            end else begin
                                mode_r <= tgt_r;
                            end
                        end
                    end
                    S_ERASE: begin
                        st_r <= S_ERASE_W;
                    end
                    S_ERASE_W: begin
                        if (cfg_done) begin
                            st_r <= S_RUN;
                            if (mem_ok) begin
                                tgt_r <= MODE_INIT;
                                st_r  <= S_CFG;
                            end
                        end
                    end
                    default: begin
                        st_r <= S_BOOT;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Memory port
    // ************************************************************
    always_comb begin
        go      = 1'b0;
        req_nxt = lnk_req;
        case (st_r)
            S_BOOT: begin
                go      = 1'b1;
                req_nxt = '{MEM_CFG_RD, CFG_ADDR, 8'h00};
            end
            S_CFG: begin
                go      = 1'b1;
                req_nxt = '{MEM_CFG_WR, CFG_ADDR, (tgt_r == MODE_TAMPERED) ? CFG_TAMPERED :
                            (tgt_r == MODE_PROTECTED) ? CFG_PROTECTED : CFG_INIT};
            end
            S_ERASE: begin
                go      = 1'b1;
                req_nxt = '{MEM_ERASE, 16'h0000, 8'h00};
            end
            S_RUN: begin
                go = lnk_go && mem_mode;
            end
            default: begin
                go = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_valid <= 1'b0;
            mem_req   <= '0;
        end else if (go) begin
            mem_valid <= 1'b1;
            mem_req   <= req_nxt;
        end else if (mem_ack) begin
            mem_valid <= 1'b0;
        end
    end

    // ************************************************************
    // Flags, halt and user write filter
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpu_halt   <= 1'b0;
            debug_en   <= 1'b0;
            mon_mem_en <= 1'b0;
            wdt_nmi_en <= 1'b0;
            boot_busy  <= 1'b1;
            mode       <= MODE_TAMPERED;
        end else begin
            mode       <= mode_r;
            boot_busy  <= (st_r == S_BOOT || st_r == S_BOOT_W);
            debug_en   <= dev;
            mon_mem_en <= mem_mode;
            wdt_nmi_en <= dev;
            if (wake_pwroff || !dev) begin
                cpu_halt <= 1'b0;
            end else if (dbg_valid && dbg_cmd.code == CMD_BREAK) begin
                cpu_halt <= 1'b1;
            end else if (dbg_valid && dbg_cmd.code == CMD_RESUME) begin
                cpu_halt <= 1'b0;
            end
        end
    end

    assign cpu_wr_grant = cpu_wr_req && (cpu_wr_addr[15:6] != CFG_BLOCK_ADDR);

endmodule : dmpc_core

// ### testbench/dmpc_mem_model.sv
// Code memory model on the far side of the memory port
`timescale 1ns/10ps
module dmpc_mem_model
    import dmpc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       mem_valid,
    input  wire dmpc_mreq_s mem_req,
    input  wire logic       fail,
    output logic            mem_ack,
    output logic            mem_ok,
    output logic [7:0]      mem_rdata,
    output logic [7:0]      cfg_r,
    output int              n_erase
);
    initial begin
        mem_ack = 1'b0;
        mem_ok = 1'b0;
        mem_rdata = 8'h00;
        cfg_r = CFG_INIT;
        n_erase = 0;
        forever begin
            @(posedge clk_sys);
            #1;
            if (mem_valid === 1'b1) begin
                repeat ($urandom % 3) @(posedge clk_sys);
                #1;
                // Only the erase can be made to fail
                mem_ok = !(fail && mem_req.op == MEM_ERASE);
                mem_rdata = cfg_r;
                if (mem_req.op == MEM_CFG_WR) cfg_r = mem_req.data;
                if (mem_ok && mem_req.op == MEM_ERASE) n_erase++;
                mem_ack = 1'b1;
                @(posedge clk_sys);
                #1;
                mem_ack = 1'b0;
                mem_rdata = ~mem_rdata;
            end
        end
    end
endmodule : dmpc_mem_model

// ### testbench/dmpc_core_asserts.sv
// Port checker for the mode protection control block
`timescale 1ns/10ps
module dmpc_core_asserts
    import dmpc_pkg::*;
(
    input wire logic       clk_sys, rstn, cpu_wr_req, cpu_wr_grant, mem_valid, mem_ack,
    input wire logic       cpu_start, boot_busy, debug_en, mon_mem_en, wdt_nmi_en, dbg_valid,
    input wire logic [15:0] cpu_wr_addr, cpu_start_vec,
    input wire dmpc_mreq_s mem_req,
    input wire dmpc_mode_e mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_grant_filter: assert property (cpu_wr_grant == (cpu_wr_req && cpu_wr_addr[15:6] != CFG_BLOCK_ADDR))
        else $error("user store reached mode bytes");
    a_debug_dev: assert property (debug_en |-> mode == MODE_INIT)
        else $error("debug enabled outside development");
    a_nmi_dev: assert property (wdt_nmi_en |-> mode == MODE_INIT)
        else $error("watchdog nmi outside development");
    a_monmem_mode: assert property (mon_mem_en |-> mode inside {MODE_INIT, MODE_VIRGIN})
        else $error("monitor memory access in locked mode");
    a_dbg_mode: assert property (dbg_valid |-> mode == MODE_INIT)
        else $error("debug command forwarded outside development");
    a_erase_tamper: assert property (mem_valid && mem_req.op == MEM_ERASE |-> mode == MODE_TAMPERED)
        else $error("erase while not tampered");
    a_boot_cfg: assert property (boot_busy && mem_valid |-> mem_req.op == MEM_CFG_RD && mem_req.addr == CFG_ADDR)
        else $error("boot did not read mode bytes");
    a_req_hold: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_req))
        else $error("memory request dropped early");
    a_start_vec: assert property (cpu_start |-> cpu_start_vec == WARM_BOOT_VEC && $past(boot_busy))
        else $error("bad hand-off after boot");
endmodule : dmpc_core_asserts
bind dmpc_core dmpc_core_asserts u_chk (.clk_sys, .rstn, .cpu_wr_req, .cpu_wr_grant, .mem_valid, .mem_ack,
    .cpu_start, .boot_busy, .debug_en, .mon_mem_en, .wdt_nmi_en, .dbg_valid, .cpu_wr_addr, .cpu_start_vec,
    .mem_req, .mode);

// ### testbench/dmpc_core_test.sv
// Self-checking bench for the mode protection control block
`timescale 1ns/10ps
module dmpc_core_test
    import dmpc_pkg::*;
();
    logic clk_sys = 0, rstn = 0, wake_pwroff = 0, sclk = 0, host_d = 0, fail = 0, cpu_wr_req = 0, rej = 0;
    logic [15:0] cpu_wr_addr = 0, cpu_start_vec, op;
    logic mem_valid, mem_ack, mem_ok, sd_o, sd_oe, cpu_wr_grant, cpu_halt, boot_busy, debug_en, mon_mem_en, cmd_reject;
    logic wdt_nmi_en;
    logic [7:0] mem_rdata, cfg_r, rx_b;
    dmpc_mreq_s mem_req;
    dmpc_mode_e mode, exp_mode;
    dmpc_dbg_s  dbg_cmd;
    int n_errors = 0, n_tests = 0, n_erase;
    wire sd = sd_oe ? sd_o : host_d;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (cmd_reject === 1'b1) rej <= 1'b1;
    dmpc_core #(.IDLE_CYC(50)) dut (.clk_sys, .rstn, .wake_pwroff, .monitor_serial_clock(sclk),
        .monitor_serial_data_i(sd), .monitor_serial_data_o(sd_o), .monitor_serial_data_oe(sd_oe), .mem_valid,
        .mem_req, .mem_ack, .mem_ok, .mem_rdata, .cpu_wr_req, .cpu_wr_addr, .cpu_wr_grant, .cpu_start(),
        .cpu_start_vec, .cpu_halt, .boot_busy, .mode, .debug_en, .mon_mem_en, .wdt_nmi_en, .cmd_reject,
        .dbg_valid(), .dbg_cmd);
    dmpc_mem_model mem (.clk_sys, .mem_valid, .mem_req, .fail, .mem_ack, .mem_ok, .mem_rdata, .cfg_r, .n_erase);
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : tick
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Link clock 800 ns, MSB first; data set while clock is low
    task send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            host_d = b[i];
            tick(4);
            rx_b = {rx_b[6:0], sd};
            sclk = 1;
            tick(4);
            sclk = 0;
        end
    endtask : send
    // Idle gap outlasts the frame timeout so frames never merge
    task frame(input logic [7:0] c, input logic [15:0] w, input bit opnd);
        send(c);
        if (opnd) begin
            send(w[15:8]);
            send(w[7:0]);
        end
        host_d = ~host_d;
        tick(80);
    endtask : frame
    task boot();
        tick(2);
        for (int k = 0; k < 100 && boot_busy !== 1'b0; k++) tick(1);
        tick(2);
    endtask : boot
    task state(input string name);
        chk("mode", exp_mode, mode);
        chk("debug_en", exp_mode == MODE_INIT, debug_en);
        chk("mon_mem_en", exp_mode inside {MODE_INIT, MODE_VIRGIN}, mon_mem_en);
        chk("wdt_nmi_en", exp_mode == MODE_INIT, wdt_nmi_en);
        $display("test %s done", name);
    endtask : state
    task final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        #3000000;
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'hd682));
        exp_mode = MODE_INIT;
        tick(6);
        rstn = 1;
        boot();
        chk("vector", WARM_BOOT_VEC, cpu_start_vec);
        state("boot");
        for (int i = 0; i < 8; i++) begin
            cpu_wr_req = i[0];
            cpu_wr_addr = 16'($urandom);
            if (i > 3) cpu_wr_addr[15:6] = CFG_BLOCK_ADDR;
            tick(1);
            chk("grant", cpu_wr_req && !(cpu_wr_addr inside {[16'h3fc0:16'h3fff]}), cpu_wr_grant);
        end
        cpu_wr_req = 0;
        op = 16'($urandom);
        frame(CMD_BREAK, op, 1);
        chk("halt", 1, cpu_halt);
        chk("operand", op, dbg_cmd.operand);
        frame(CMD_RESUME, 0, 1);
        chk("halt", 0, cpu_halt);
        state("debug");
        frame(CMD_PROTECT, 0, 0);
        wake_pwroff = 1;
        tick(1);
        wake_pwroff = 0;
        boot();
        exp_mode = MODE_PROTECTED;
        chk("cfg", CFG_PROTECTED, cfg_r);
        state("protect");
        // Zero operand: a locked device parses these bytes as commands
        frame(CMD_BREAK, 16'h0000, 1);
        chk("reject", 1, rej);
        chk("halt", 0, cpu_halt);
        send(CMD_STATUS);
        frame(8'h00, 0, 0);
        chk("status", {1'b1, 2'b00, 3'h0, MODE_PROTECTED}, rx_b);
        fail = 1;
        frame(CMD_RETURN_INIT, 0, 0);
        exp_mode = MODE_TAMPERED;
        chk("erases", 0, n_erase);
        state("failed return");
        fail = 0;
        frame(CMD_RETURN_INIT, 0, 0);
        exp_mode = MODE_INIT;
        chk("erases", 1, n_erase);
        chk("cfg", CFG_INIT, cfg_r);
        state("retry");
        rstn = 0;
        tick(2);
        rstn = 1;
        boot();
        state("reboot");
        final_report();
    end
endmodule : dmpc_core_test
